/* File: design/des_core_defines.vh */
// Constants and permutation tables for the block cipher core
`ifndef DES_CORE_DEFINES_VH
`define DES_CORE_DEFINES_VH

// Widths
`define DES_BLK_W      64
`define DES_HALF_W     32
`define DES_CD_W       56
`define DES_KHALF_W    28
`define DES_SUBKEY_W   48
`define DES_RND_W      4
`define DES_ENT_W      8
`define DES_NIB_W      4
`define DES_SIX_W      6
`define DES_NUM_SBOX   8
`define DES_SBOX_ENT   64
`define DES_SBOX_COLS  16

// Round indices
`define DES_RND_FIRST  4'h0
`define DES_RND_LAST_REG 4'he
`define DES_RND_FINAL  4'hf
`define DES_RND_ONE    4'h1

// Initial permutation, one byte per entry, first entry in the top byte
`define DES_IP_TAB {64'h3a322a221a120a02, 64'h3c342c241c140c04, \
	64'h3e362e261e160e06, 64'h4038302820181008, 64'h3931292119110901, \
	64'h3b332b231b130b03, 64'h3d352d251d150d05, 64'h3f372f271f170f07}

// Key selection into the two 28-bit halves
`define DES_PC1_TAB {64'h3931292119110901, 64'h3a322a221a120a02, \
	64'h3b332b231b130b03, 64'h3c342c243f372f27, 64'h1f170f073e362e26, \
	64'h1e160e063d352d25, 64'h1d150d051c140c04}

// Round key compression
`define DES_PC2_TAB {64'h0e110b180105031c, 64'h0f06150a17130c04, \
	64'h1a0810071b140d02, 64'h29341f252f371e28, 64'h332d21302c312738, \
	64'h22352e2a32241d20}

// Cumulative left rotation of the key halves per round
`define DES_SHIFT_TAB {64'h01020406080a0c0e, 64'h0f11131517191b1c}

// Permutation after substitution
`define DES_P_TAB {64'h100714151d0c1c11, 64'h010f171a05121f0a, \
	64'h0208180e201b0309, 64'h130d1e06160b0419}

// Substitution boxes, row-major, first entry in the top nibble
`define DES_SBOX_TAB {256'he4d12fb83a6c59070f74e2d1a6cb953841e8d62bfc973a50fc8249175b3ea06d, \
	256'hf18e6b34972dc05a3d47f28ec01a69b50e7ba4d158c6932fd8a13f42b67c05e9, \
	256'ha09e63f51dc7b428d709346a285ecbf1d6498f30b12c5ae71ad069874fe3b52c, \
	256'h7de3069a1285bc4fd8b56f03472c1ae9a690cb7df13e52843f06a1d8945bc72e, \
	256'h2c417ab6853fd0e9eb2c47d150fa3986421bad78f9c5630eb8c71e2d6f09a453, \
	256'hc1af92680d34e75baf427c9561de0b389ef528c3704a1db6432c95fabe17608d, \
	256'h4b2ef08d3c975a61d0b7491ae35c2f8614bdc37eaf6805926bd814a7950fe23c, \
	256'hd2846fb1a93e50c71fd8a374c56b0e927b419ce206adf35821e74a8dfc90356b}

`endif

/* File: design/des_round.v */
// One combinational cipher round: expansion, key mix, substitution, permute
`timescale 1ns/1ps
`default_nettype none
`include "des_core_defines.vh"

module des_round (
	input  wire [`DES_HALF_W-1:0]   left_in,
	input  wire [`DES_HALF_W-1:0]   right_in,
	input  wire [`DES_SUBKEY_W-1:0] subkey,
	output wire [`DES_HALF_W-1:0]   left_out,
	output wire [`DES_HALF_W-1:0]   right_out
);

localparam [255:0]  p_tab    = `DES_P_TAB;
localparam [2047:0] sbox_tab = `DES_SBOX_TAB;

////////////////////////////////////////////////////////////////////////////////
// Expansion of 32 bits into eight overlapping 6-bit groups
function [`DES_SUBKEY_W-1:0] expand;
	input [`DES_HALF_W-1:0] r;
	integer g;
	integer k;
	begin
		expand = {`DES_SUBKEY_W{1'b0}};
		for (g = 0; g < `DES_NUM_SBOX; g = g + 1) begin
			for (k = 0; k < `DES_SIX_W; k = k + 1) begin
				expand[`DES_SUBKEY_W-1-(`DES_SIX_W*g+k)] =
					r[`DES_HALF_W-1-((`DES_NIB_W*g+k+`DES_HALF_W-1)
					% `DES_HALF_W)];
			end
		end
	end
endfunction

// Substitution of all eight groups
function [`DES_HALF_W-1:0] substitute;
	input [`DES_SUBKEY_W-1:0] x;
	integer g;
	integer idx;
	reg [`DES_SIX_W-1:0] b;
	begin
		substitute = {`DES_HALF_W{1'b0}};
		for (g = 0; g < `DES_NUM_SBOX; g = g + 1) begin
			b = x[`DES_SUBKEY_W-1-`DES_SIX_W*g -: `DES_SIX_W];
			idx = {b[5], b[0]} * `DES_SBOX_COLS + b[4:1];
			substitute[`DES_HALF_W-1-`DES_NIB_W*g -: `DES_NIB_W] =
				sbox_tab[`DES_NIB_W*(`DES_SBOX_ENT*(`DES_NUM_SBOX-g)
				- 1 - idx) +: `DES_NIB_W];
		end
	end
endfunction

// Fixed bit permutation of the substitution result
function [`DES_HALF_W-1:0] permute;
	input [`DES_HALF_W-1:0] x;
	integer j;
	reg [`DES_ENT_W-1:0] t;
	begin
		permute = {`DES_HALF_W{1'b0}};
		for (j = 0; j < `DES_HALF_W; j = j + 1) begin
			t = p_tab[`DES_ENT_W*(`DES_HALF_W-1-j) +: `DES_ENT_W];
			permute[`DES_HALF_W-1-j] = x[`DES_HALF_W-t];
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Round: swap halves, mix the cipher function into the new right half
assign left_out  = right_in;
assign right_out = left_in ^ permute(substitute(expand(right_in) ^ subkey));

endmodule // des_round

`default_nettype wire

/* File: design/des_core.v */
// Block cipher core: start handshake, round sequencing and key schedule
`timescale 1ns/1ps
`default_nettype none
`include "des_core_defines.vh"

// Behaviour
// - A full encryption or decryption takes fifteen clock cycles after the block is loaded.
// - Each 64-bit block is ciphered under a 56-bit key by standard rounds.
// - The key port is 64 bits; the 8 parity bits are ignored, unchecked.
// - The data block is captured when a conversion starts; later changes ignored.
// - Start is synchronised; a conversion begins after its rising edge.
// - Direction is captured at start; 1 encrypts, 0 decrypts.
// - The result appears on its output in the cycle done rises.
// - Done rises when the result is ready and holds until the next start.
// - The active-low reset acts asynchronously, independent of the clock.
// - One clock only; no generated or gated clocks.
// - Done rises a fixed count of cycles after start rises.
// - The key is not stored; the result follows the key at all times.
// - Once done is high, the result stays stable until the next start while inputs are steady.
module des_core (
	input  wire                  clock,
	input  wire                  rst_n,
	input  wire                  start,
	input  wire                  encrypt,
	input  wire [`DES_BLK_W-1:0] data_in,
	input  wire [`DES_BLK_W-1:0] key,
	output wire [`DES_BLK_W-1:0] result,
	output reg                   done
);

localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_RUN  = 2'h1;
localparam [1:0] ST_DONE = 2'h2;

localparam [511:0] ip_tab    = `DES_IP_TAB;
localparam [447:0] pc1_tab   = `DES_PC1_TAB;
localparam [383:0] pc2_tab   = `DES_PC2_TAB;
localparam [127:0] shift_tab = `DES_SHIFT_TAB;

////////////////////////////////////////////////////////////////////////////////
// Permutation and key schedule functions

// Initial permutation of the data block
function [`DES_BLK_W-1:0] init_perm;
	input [`DES_BLK_W-1:0] x;
	integer i;
	reg [`DES_ENT_W-1:0] t;
	begin
		init_perm = {`DES_BLK_W{1'b0}};
		for (i = 0; i < `DES_BLK_W; i = i + 1) begin
			t = ip_tab[`DES_ENT_W*(`DES_BLK_W-1-i) +: `DES_ENT_W];
			init_perm[`DES_BLK_W-1-i] = x[`DES_BLK_W-t];
		end
	end
endfunction

// Final permutation, the inverse of the initial one
function [`DES_BLK_W-1:0] final_perm;
	input [`DES_BLK_W-1:0] x;
	integer i;
	reg [`DES_ENT_W-1:0] t;
	begin
		final_perm = {`DES_BLK_W{1'b0}};
		for (i = 0; i < `DES_BLK_W; i = i + 1) begin
			t = ip_tab[`DES_ENT_W*(`DES_BLK_W-1-i) +: `DES_ENT_W];
			final_perm[`DES_BLK_W-t] = x[`DES_BLK_W-1-i];
		end
	end
endfunction

// Round key for a round number, straight from the key port
function [`DES_SUBKEY_W-1:0] round_key;
	input [`DES_BLK_W-1:0] k;
	input [`DES_RND_W-1:0] rnd;
	integer i;
	reg [`DES_ENT_W-1:0] t;
	reg [`DES_ENT_W-1:0] sh;
	reg [`DES_CD_W-1:0] cd;
	reg [`DES_CD_W-1:0] c2;
	reg [`DES_CD_W-1:0] d2;
	reg [`DES_CD_W-1:0] rot;
	begin
		cd = {`DES_CD_W{1'b0}};
		round_key = {`DES_SUBKEY_W{1'b0}};
		// Parity bits never appear in the selection table
		for (i = 0; i < `DES_CD_W; i = i + 1) begin
			t = pc1_tab[`DES_ENT_W*(`DES_CD_W-1-i) +: `DES_ENT_W];
			cd[`DES_CD_W-1-i] = k[`DES_BLK_W-t];
		end
		sh = shift_tab[`DES_ENT_W*(`DES_RND_FINAL-rnd) +: `DES_ENT_W];
		c2 = {cd[`DES_CD_W-1:`DES_KHALF_W], cd[`DES_CD_W-1:`DES_KHALF_W]}
			<< sh;
		d2 = {cd[`DES_KHALF_W-1:0], cd[`DES_KHALF_W-1:0]} << sh;
		rot = {c2[`DES_CD_W-1:`DES_KHALF_W], d2[`DES_CD_W-1:`DES_KHALF_W]};
		for (i = 0; i < `DES_SUBKEY_W; i = i + 1) begin
			t = pc2_tab[`DES_ENT_W*(`DES_SUBKEY_W-1-i) +: `DES_ENT_W];
			round_key[`DES_SUBKEY_W-1-i] = rot[`DES_CD_W-t];
		end
	end
endfunction

// Key index for a round, reversed for decryption
function [`DES_RND_W-1:0] key_index;
	input                  enc;
	input [`DES_RND_W-1:0] rnd;
	begin
		key_index = enc ? rnd : `DES_RND_FINAL - rnd;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Registers

reg  [1:0]             state_reg;
reg  [1:0]             state_next;
reg  [`DES_RND_W-1:0]  rnd_reg;
reg  [`DES_HALF_W-1:0] left_reg;
reg  [`DES_HALF_W-1:0] right_reg;
reg                    encrypt_reg;
reg                    start_meta_reg;
reg                    start_sync_reg;
reg                    start_prev_reg;

wire                   start_edge;
wire [`DES_BLK_W-1:0]  ip_data;
wire [`DES_HALF_W-1:0] step_left;
wire [`DES_HALF_W-1:0] step_right;
wire [`DES_HALF_W-1:0] fin_left;
wire [`DES_HALF_W-1:0] fin_right;

////////////////////////////////////////////////////////////////////////////////
// Start synchroniser and edge detect

always @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		start_meta_reg <= 1'b0;
		start_sync_reg <= 1'b0;
		start_prev_reg <= 1'b0;
	end else begin
		start_meta_reg <= start;
		start_sync_reg <= start_meta_reg;
		start_prev_reg <= start_sync_reg;
	end
end

assign start_edge = start_sync_reg & ~start_prev_reg;

////////////////////////////////////////////////////////////////////////////////
// Round datapath: registered rounds and the final open round

assign ip_data = init_perm(data_in);

des_round u_step (
	.left_in   (left_reg),
	.right_in  (right_reg),
	.subkey    (round_key(key, key_index(encrypt_reg, rnd_reg))),
	.left_out  (step_left),
	.right_out (step_right)
);

// Last round runs from the live key so the result tracks it
des_round u_final (
	.left_in   (left_reg),
	.right_in  (right_reg),
	.subkey    (round_key(key, key_index(encrypt_reg, `DES_RND_FINAL))),
	.left_out  (fin_left),
	.right_out (fin_right)
);

// Halves swapped before the final permutation
assign result = final_perm({fin_right, fin_left});

////////////////////////////////////////////////////////////////////////////////
// Controller

always @* begin
	state_next = state_reg;
	case (state_reg)
		ST_IDLE: begin
			if (start_edge)
				state_next = ST_RUN;
		end
		ST_RUN: begin
			if (start_edge)
				state_next = ST_RUN;
			else if (rnd_reg == `DES_RND_LAST_REG)
				state_next = ST_DONE;
		end
		ST_DONE: begin
			if (start_edge)
				state_next = ST_RUN;
		end
		default: state_next = ST_IDLE;
	endcase
end

always @(posedge clock or negedge rst_n) begin
	if (!rst_n) begin
		state_reg   <= ST_IDLE;
		done        <= 1'b0;
		rnd_reg     <= `DES_RND_FIRST;
		left_reg    <= {`DES_HALF_W{1'b0}};
		right_reg   <= {`DES_HALF_W{1'b0}};
		encrypt_reg <= 1'b0;
	end else begin
		state_reg <= state_next;
		if (start_edge) begin
			left_reg    <= ip_data[`DES_BLK_W-1:`DES_HALF_W];
			right_reg   <= ip_data[`DES_HALF_W-1:0];
			encrypt_reg <= encrypt;
			rnd_reg     <= `DES_RND_FIRST;
			done        <= 1'b0;
		end else if (state_reg == ST_RUN) begin
			left_reg  <= step_left;
			right_reg <= step_right;
			rnd_reg   <= rnd_reg + `DES_RND_ONE;
			if (rnd_reg == `DES_RND_LAST_REG)
				done <= 1'b1;
		end
	end
end

endmodule // des_core

`default_nettype wire

/* File: tb/des_core_properties.sv */
// Timing checker for the block cipher core
`timescale 1ns/1ps
`default_nettype none
module des_core_properties (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        start,
	input wire logic        encrypt,
	input wire logic [63:0] data_in,
	input wire logic [63:0] key,
	input wire logic [63:0] result,
	input wire logic        done
);
	localparam logic [63:0] par_bits = 64'h0101010101010101;
	logic [2:0] sync_reg;
	logic [3:0] cnt_reg;
	logic       go;
	////////////////////////////////////////////////////////////////////////
	// Start edge and round count mirror
	assign go = sync_reg[1] & ~sync_reg[2];
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync_reg <= 3'h0;
			cnt_reg  <= 4'h0;
		end else begin
			sync_reg <= {sync_reg[1:0], start};
			if (go)
				cnt_reg <= 4'h1;
			else if (cnt_reg != 4'h0)
				cnt_reg <= cnt_reg + 4'h1;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Properties
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_busy_done_low: assert property (cnt_reg != 4'h0 |-> !done)
		else $error("done high during conversion");
	a_done_rises: assert property (cnt_reg == 4'hf && !go |=> done)
		else $error("done late");
	a_done_cause: assert property ($rose(done) |-> $past(cnt_reg) == 4'hf)
		else $error("done rose at wrong time");
	a_done_holds: assert property (done && !go |=> done)
		else $error("done dropped without start");
	a_start_drops: assert property ($rose(start) |-> ##3 !done)
		else $error("start edge not taken");
	a_key_follows: assert property (done && $past(done) && $past(done, 2)
		&& ((key ^ $past(key)) & ~par_bits) != 64'h0
		&& ((key ^ $past(key, 2)) & ~par_bits) == 64'h0
		|-> result == $past(result, 2)) else $error("result lags key");
	a_parity_ignored: assert property (done && $past(done)
		&& ((key ^ $past(key)) & ~par_bits) == 64'h0
		|-> $stable(result)) else $error("result moved");
	a_reset_clears: assert property (@(posedge clock) disable iff (1'b0)
		!rst_n |-> !done) else $error("done high in reset");
endmodule // des_core_properties

bind des_core des_core_properties chk (.clock(clock), .rst_n(rst_n),
	.start(start), .encrypt(encrypt), .data_in(data_in), .key(key),
	.result(result), .done(done));
`default_nettype wire

/* File: tb/des_host.sv */
// Host logic model driving the cipher core
`timescale 1ns/1ps
`default_nettype none
module des_host (
	input  wire logic        clock,
	input  wire logic        done,
	input  wire logic [63:0] result,
	output var  logic        start,
	output var  logic        encrypt,
	output var  logic [63:0] data_in,
	output var  logic [63:0] key
);
	initial begin
		start = 1'b0;
		encrypt = 1'b0;
		data_in = 64'h0;
		key = 64'h0;
	end
	task automatic set_key(input logic [63:0] k);
		@(negedge clock);
		key = k;
		// Let the combinational result settle before anyone looks
		#1;
	endtask
	task automatic convert(input logic [63:0] blk, input logic [63:0] k,
		input logic enc, input int width, output int edges,
		output logic [63:0] res);
		@(negedge clock);
		data_in = blk;
		encrypt = enc;
		key = k;
		@(negedge clock);
		start = 1'b1;
		edges = 0;
		res = 64'h0;
		for (int i = 1; i <= 40 && edges == 0; i++) begin
			@(negedge clock);
			if (i == width)
				start = 1'b0;
			if (i == 3) begin
				data_in = ~blk;
				encrypt = ~enc;
			end
			if (i > 2 && done === 1'b1)
				edges = i;
		end
		start = 1'b0;
		@(posedge clock);
		res = result;
	endtask
endmodule // des_host
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the block cipher core
`timescale 1ns/1ps
`default_nettype none
`define check(got, exp, msg) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) begin \
			n_mismatch++; \
			$display("ERROR %0t %s", $time, msg); \
		end \
	end
module testbench;
	typedef struct {
		logic [63:0] blk;
		logic [63:0] k;
		logic        enc;
		logic [63:0] exp;
	} row_t;
	logic        clock;
	logic        rst_n;
	logic        start;
	logic        encrypt;
	logic [63:0] data_in;
	logic [63:0] key;
	logic [63:0] result;
	logic        done;
	logic [63:0] res;
	int          edges;
	int          n_mismatch = 0;
	int          tests_run = 0;
	row_t        rows [5] = '{
		'{64'h0123456789abcdef, 64'h133457799bbcdff1, 1'b1, 64'h85e813540f0ab405},
		'{64'h85e813540f0ab405, 64'h133457799bbcdff1, 1'b0, 64'h0123456789abcdef},
		'{64'h0123456789abcdef, 64'h123556789abddef0, 1'b1, 64'h85e813540f0ab405},
		'{64'h8787878787878787, 64'h0e329232ea6d0d73, 1'b1, 64'h0000000000000000},
		'{64'h0000000000000000, 64'h0e329232ea6d0d73, 1'b0, 64'h8787878787878787}};
	des_host host (.clock(clock), .done(done), .result(result), .start(start),
		.encrypt(encrypt), .data_in(data_in), .key(key));
	des_core uut (.clock(clock), .rst_n(rst_n), .start(start),
		.encrypt(encrypt), .data_in(data_in), .key(key), .result(result),
		.done(done));
	////////////////////////////////////////////////////////////////////////
	// Clock, verdict and watchdog
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task automatic conclude;
		if (n_mismatch == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#10000;
		n_mismatch++;
		conclude();
	end
	////////////////////////////////////////////////////////////////////////
	// Table cases, then hand-written cases
	initial begin
		rst_n = 1'b0;
		repeat (6) @(negedge clock);
		`check(done, 1'b0, "done during reset")
		rst_n = 1'b1;
		foreach (rows[i]) begin
			host.convert(rows[i].blk, rows[i].k, rows[i].enc, 1, edges, res);
			`check(edges, 18, "latency")
			`check(res, rows[i].exp, "cipher")
		end
		host.convert(rows[0].blk, rows[0].k, 1'b1, 30, edges, res);
		`check(edges, 18, "long start latency")
		repeat (5) @(negedge clock);
		`check(done, 1'b1, "done held")
		`check(result, rows[0].exp, "result held")
		host.set_key(rows[3].k);
		`check(result === rows[0].exp, 1'b0, "key not followed")
		host.set_key(rows[2].k);
		`check(result, rows[0].exp, "parity changed result")
		host.set_key(rows[0].k);
		`check(result, rows[0].exp, "key restore")
		#1 rst_n = 1'b0;
		#0.5 `check(done, 1'b0, "async reset")
		@(negedge clock);
		rst_n = 1'b1;
		fork
			host.convert(rows[1].blk, rows[1].k, 1'b0, 1, edges, res);
			begin
				repeat (8) @(negedge clock);
				rst_n = 1'b0;
				@(negedge clock);
				rst_n = 1'b1;
			end
		join
		`check(edges, 0, "conversion survived reset")
		host.convert(rows[1].blk, rows[1].k, 1'b0, 1, edges, res);
		`check(res, rows[1].exp, "after reset")
		conclude();
	end
endmodule // testbench
`default_nettype wire
